// [ttr_pkg.sv]
// Constants, types and register map of the trace trigger resources block
// Behaviour
// [RULE1] Sequencer has three states; any state may go to any state each cycle.
// [RULE2] Sequencer moves only on internal trace events, never on external inputs.
// [RULE3] Trigger event may be qualified by the current sequencer state.
// [RULE4] Single comparator matches fetch address or data address against programmed value.
// [RULE5] Range mode pairs comparators into one address range resource.
// [RULE6] Pair matches when start <= address and address < end.
// [RULE7] Software must configure both comparators of a pair identically.
// [RULE8] Each comparator has a data comparator sampling only on loads and stores.
// [RULE9] Data comparator checks only unmasked bits of its value against the bus.
// [RULE10] Region inputs flag external bus, user and system peripheral windows.
// [RULE11] Region inputs flag on-chip SRAM and ROM windows for data and fetch.
// [RULE12] A 45-byte FIFO decouples packet output from pipeline status output.
// [RULE13] Overflow flagged when FIFO full or free bytes fall below threshold.
// [RULE14] New trace data is presented at both edges of the trace clock.
// [RULE15] Capture equipment must sample on both edges of the trace clock.
// [RULE16] Trace clock runs at half the processor clock.
// [RULE17] Status lines report core state each trace clock edge with matching packets.
// [RULE18] Packets are 8 bits wide, at most two per cycle on the lines.
// [RULE19] Sync flag marks start of a branch sequence on the packet lines; the code flags only a byte sent on lines [7:0].
// [RULE20] Sequencer holds without an enabled event and starts in first state.
package ttr_pkg;

    localparam int FIFO_DEPTH = 45;
    localparam int NUM_CMP    = 4;

    // ************************************************
    // Register offsets and fields
    // ************************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SEQ  = 8'h04;
    localparam logic [7:0] A_TRIG = 8'h08;
    localparam logic [7:0] A_FTHR = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [1:0] A_CMP_BLK = 2'h1;
    localparam logic [1:0] CMP_ADDR = 2'h0;
    localparam logic [1:0] CMP_CFG  = 2'h1;
    localparam logic [1:0] CMP_DVAL = 2'h2;
    localparam logic [1:0] CMP_DMSK = 2'h3;

    localparam int CTRL_EN       = 0;
    localparam int CTRL_RANGE    = 1;
    localparam int SEQ_FW        = 4;
    localparam int TRIG_MASK_LSB = 4;
    localparam int STAT_OVF      = 2;
    localparam int STAT_CNT_LSB  = 8;

    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [23:0] SEQ_RST  = 24'hffffff;
    localparam logic [6:0]  TRIG_RST = 7'h0f;
    localparam logic [5:0]  FTHR_RST = 6'h00;

    // Resource vector layout
    localparam int RES_RANGE_LSB  = 4;
    localparam int RES_REGION_LSB = 6;
    localparam int RES_ALWAYS     = 14;

    // ************************************************
    // Region decoder windows
    // ************************************************
    localparam logic [31:0] REG_LO [8] = '{32'h00000000, 32'h00000000, 32'h00400000,
        32'h00400000, 32'h10000000, 32'h10000000, 32'hf0000000, 32'hffffc000};
    localparam logic [31:0] REG_HI [8] = '{32'h002fffff, 32'h002fffff, 32'h004fffff,
        32'h004fffff, 32'h9fffffff, 32'h9fffffff, 32'hffffbfff, 32'hffffffff};
    localparam logic [7:0] REG_IS_DATA = 8'hd5;

    typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_THIRD} ttr_seq_t;

    typedef struct packed {
        logic dcmp_en;
        logic use_data;
    } ttr_cmp_cfg_t;

    typedef struct packed {
        logic        fetch_vld;
        logic [31:0] fetch_addr;
        logic        data_vld;
        logic        data_ldst;
        logic [31:0] data_addr;
        logic [31:0] data_val;
        logic [2:0]  pstat;
    } ttr_core_obs_t;

    typedef struct packed {
        logic       vld;
        logic       sync;
        logic [7:0] data;
    } ttr_pkt_t;

endpackage

// [ttr_trace_unit.sv]
// Trace trigger resources, packet FIFO and half-rate trace port
`timescale 1ns/100ps
module ttr_trace_unit
    import ttr_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic [31:0]        hrdata,
    output logic               hresp,
    input  wire ttr_core_obs_t core_obs,
    input  wire ttr_pkt_t      pkt_in,
    output logic               trace_port_clock,
    output logic [2:0]         pipeline_status_lines,
    output logic [15:0]        trace_packet_lines,
    output logic               branch_sync_flag,
    output logic               trigger_out
);

    // ************************************************
    // Functions
    // ************************************************
    function automatic logic in_window(input logic [31:0] a, lo, hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic res_pick(input logic [3:0] sel, input logic [15:0] res);
        res_pick = res[sel];
    endfunction

    function automatic logic [5:0] ptr_inc(input logic [5:0] p);
        ptr_inc = (p == 6'(DEPTH - 1)) ? 6'h00 : p + 6'h01;
    endfunction

    // ************************************************
    // Registers
    // ************************************************
    logic [1:0]   ctrl_reg;
    logic [23:0]  seq_reg;
    logic [6:0]   trig_reg;
    logic [5:0]   fthr_reg;
    logic         ovf_reg;
    logic [31:0]  cmp_addr_reg [NUM_CMP];
    ttr_cmp_cfg_t cmp_cfg_reg  [NUM_CMP];
    logic [31:0]  cmp_dval_reg [NUM_CMP];
    logic [31:0]  cmp_dmsk_reg [NUM_CMP];
    ttr_seq_t     seq_reg_st;
    ttr_seq_t     seq_next;

    // ************************************************
    // AHB-Lite slave
    // ************************************************
    logic       wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic       addr_take;
    logic [31:0] rd_mux;
    logic [1:0] rd_idx;
    logic [1:0] wr_idx;
    logic       wr_cmp;
    logic       trace_en;
    logic       range_mode;

    assign addr_take  = hsel && htrans[1] && hready;
    assign rd_idx     = haddr[5:4];
    assign wr_idx     = wr_addr_reg[5:4];
    assign wr_cmp     = wr_pend_reg && (wr_addr_reg[7:6] == A_CMP_BLK);
    assign trace_en   = ctrl_reg[CTRL_EN];
    assign range_mode = ctrl_reg[CTRL_RANGE];

    logic [5:0] cnt_reg;

    always_comb begin
        rd_mux = 32'h00000000;
        if (haddr[7:6] == A_CMP_BLK) begin
            case (haddr[3:2])
                CMP_ADDR: rd_mux = cmp_addr_reg[rd_idx];
                CMP_CFG:  rd_mux = {30'h00000000, cmp_cfg_reg[rd_idx]};
                CMP_DVAL: rd_mux = cmp_dval_reg[rd_idx];
                default:  rd_mux = cmp_dmsk_reg[rd_idx];
            endcase
        end else begin
            case (haddr[7:0])
                A_CTRL:  rd_mux = {30'h00000000, ctrl_reg};
                A_SEQ:   rd_mux = {8'h00, seq_reg};
                A_TRIG:  rd_mux = {25'h0000000, trig_reg};
                A_FTHR:  rd_mux = {26'h0000000, fthr_reg};
                A_STAT:  rd_mux = {18'h00000, cnt_reg, 5'h00, ovf_reg, seq_reg_st};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            wr_pend_reg <= addr_take && hwrite && (hsize == 3'h2);
            wr_addr_reg <= haddr[7:0];
            if (addr_take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    logic ovf_clr;
    assign ovf_clr = wr_pend_reg && (wr_addr_reg == A_STAT) && hwdata[STAT_OVF];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_reg <= CTRL_RST;
            seq_reg  <= SEQ_RST;
            trig_reg <= TRIG_RST;
            fthr_reg <= FTHR_RST;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                A_CTRL:  ctrl_reg <= hwdata[1:0];
                A_SEQ:   seq_reg  <= hwdata[23:0];
                A_TRIG:  trig_reg <= hwdata[6:0];
                A_FTHR:  fthr_reg <= hwdata[5:0];
                default: ;
            endcase
        end
    end

    // ************************************************
    // Comparators and region decoders
    // ************************************************
    logic [15:0] res_vec;
    logic [NUM_CMP-1:0] cmp_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            logic [31:0] src;
            logic        src_vld;
            logic        dat_ok;
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    cmp_addr_reg[gi] <= 32'h00000000;
                    cmp_cfg_reg[gi]  <= '0;
                    cmp_dval_reg[gi] <= 32'h00000000;
                    cmp_dmsk_reg[gi] <= 32'h00000000;
                end else if (wr_cmp && (wr_idx == 2'(gi))) begin
                    case (wr_addr_reg[3:2])
                        CMP_ADDR: cmp_addr_reg[gi] <= hwdata;
                        CMP_CFG:  cmp_cfg_reg[gi]  <= hwdata[1:0];
                        CMP_DVAL: cmp_dval_reg[gi] <= hwdata;
                        default:  cmp_dmsk_reg[gi] <= hwdata;
                    endcase
                end
            end
            // Fetch or data address as source
            assign src = cmp_cfg_reg[gi].use_data ? core_obs.data_addr : core_obs.fetch_addr; // RULE4
            assign src_vld = cmp_cfg_reg[gi].use_data ? core_obs.data_vld : core_obs.fetch_vld;
            // Mask bit set means the bit is ignored
            assign dat_ok = !cmp_cfg_reg[gi].dcmp_en ||
                (core_obs.data_vld && core_obs.data_ldst && // RULE8
                 (((core_obs.data_val ^ cmp_dval_reg[gi]) & ~cmp_dmsk_reg[gi]) == 32'h0)); // RULE9
            assign cmp_hit[gi] = src_vld && (src == cmp_addr_reg[gi]) && dat_ok; // RULE4
            assign res_vec[gi] = !range_mode && cmp_hit[gi];
        end
        for (gi = 0; gi < NUM_CMP / 2; gi++) begin : g_rng
            logic [31:0] src;
            logic        src_vld;
            // Pair follows the first comparator's setup; mismatched setups are undefined
            assign src = cmp_cfg_reg[2*gi].use_data ? core_obs.data_addr : core_obs.fetch_addr;
            assign src_vld = cmp_cfg_reg[2*gi].use_data ? core_obs.data_vld
                                                        : core_obs.fetch_vld;
            assign res_vec[RES_RANGE_LSB+gi] = range_mode && src_vld && // RULE5
                (src >= cmp_addr_reg[2*gi]) && (src < cmp_addr_reg[2*gi+1]); // RULE6
        end
        for (gi = 0; gi < 8; gi++) begin : g_reg
            logic [31:0] src;
            logic        src_vld;
            assign src = REG_IS_DATA[gi] ? core_obs.data_addr : core_obs.fetch_addr;
            assign src_vld = REG_IS_DATA[gi] ? core_obs.data_vld : core_obs.fetch_vld;
            assign res_vec[RES_REGION_LSB+gi] = src_vld &&
                in_window(src, REG_LO[gi], REG_HI[gi]); // RULE10 RULE11
        end
    endgenerate

    assign res_vec[RES_ALWAYS]   = 1'b1;
    assign res_vec[RES_ALWAYS+1] = 1'b0;

    // ************************************************
    // Sequencer and trigger
    // ************************************************
    // Six transition selects: 0->1, 0->2, 1->2, 1->0, 2->0, 2->1
    logic [5:0] tr_hit;
    logic       trig_hit;

    generate
        for (gi = 0; gi < 6; gi++) begin : g_tr
            assign tr_hit[gi] = res_pick(seq_reg[gi*SEQ_FW +: SEQ_FW], res_vec); // RULE2
        end
    endgenerate

    always_comb begin
        seq_next = seq_reg_st; // RULE20
        case (seq_reg_st) // RULE1
            ST_FIRST: begin
                if (tr_hit[0]) seq_next = ST_SECOND;
                else if (tr_hit[1]) seq_next = ST_THIRD;
            end
            ST_SECOND: begin
                if (tr_hit[2]) seq_next = ST_THIRD;
                else if (tr_hit[3]) seq_next = ST_FIRST;
            end
            ST_THIRD: begin
                if (tr_hit[4]) seq_next = ST_FIRST;
                else if (tr_hit[5]) seq_next = ST_SECOND;
            end
            default: seq_next = ST_FIRST;
        endcase
    end

    assign trig_hit = res_pick(trig_reg[3:0], res_vec) &&
                      trig_reg[TRIG_MASK_LSB + seq_reg_st]; // RULE3

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            seq_reg_st  <= ST_FIRST; // RULE20
            trigger_out <= 1'b0;
        end else begin
            seq_reg_st  <= trace_en ? seq_next : ST_FIRST; // RULE1
            trigger_out <= trace_en && trig_hit;
        end
    end

    // ************************************************
    // Packet FIFO
    // ************************************************
    // Entries keep the sync mark beside the byte so the flag stays aligned
    logic [8:0] fifo_mem [DEPTH];
    logic [5:0] wr_ptr_reg;
    logic [5:0] rd_ptr_reg;
    logic [5:0] rd_ptr_p1;
    logic       full;
    logic       push;
    logic [1:0] pop_n;
    logic [5:0] free_n;
    logic       ovf_hit;

    assign full      = (cnt_reg == 6'(DEPTH));
    assign push      = trace_en && pkt_in.vld && !full;
    assign pop_n     = !trace_en ? 2'd0 : (cnt_reg >= 6'd2) ? 2'd2 : cnt_reg[1:0]; // RULE18
    assign rd_ptr_p1 = ptr_inc(rd_ptr_reg);
    assign free_n    = 6'(DEPTH) - cnt_reg;
    assign ovf_hit   = trace_en && (full || (free_n < fthr_reg)); // RULE13

    always_ff @(posedge clk_sys) begin
        if (push) begin
            fifo_mem[wr_ptr_reg] <= {pkt_in.sync, pkt_in.data}; // RULE12
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr_reg <= 6'h00;
            rd_ptr_reg <= 6'h00;
            cnt_reg    <= 6'h00;
            ovf_reg    <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop_n == 2'd2) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_p1);
            end else if (pop_n == 2'd1) begin
                rd_ptr_reg <= rd_ptr_p1;
            end
            cnt_reg <= cnt_reg + {5'h00, push} - {4'h0, pop_n};
            // A new overflow in the clearing cycle keeps the flag set
            ovf_reg <= ovf_hit || (ovf_reg && !ovf_clr); // RULE13
        end
    end

    // ************************************************
    // Half-rate trace port
    // ************************************************
    // Port lines change every processor cycle, i.e. at each trace clock edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            trace_port_clock      <= 1'b0;
            pipeline_status_lines <= 3'h0;
            trace_packet_lines    <= 16'h0000;
            branch_sync_flag      <= 1'b0;
        end else begin
            trace_port_clock      <= trace_en && !trace_port_clock; // RULE16
            pipeline_status_lines <= trace_en ? core_obs.pstat : 3'h0; // RULE17 RULE14
            trace_packet_lines[7:0]  <= (pop_n != 2'd0) ? fifo_mem[rd_ptr_reg][7:0]
                                                        : 8'h00; // RULE18
            trace_packet_lines[15:8] <= (pop_n == 2'd2) ? fifo_mem[rd_ptr_p1][7:0]
                                                        : 8'h00; // RULE18
            branch_sync_flag <= (pop_n != 2'd0) && fifo_mem[rd_ptr_reg][8]; // RULE19
        end
    end

endmodule // ttr_trace_unit

// [ttr_trace_unit_assertions.sv]
// Concurrent checks on the trace trigger resources ports
`timescale 1ns/100ps
module ttr_trace_unit_chk
    import ttr_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic          clk_sys,
    input wire logic          srst,
    input wire logic          hsel,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic [31:0]   hrdata,
    input wire logic          hresp,
    input wire ttr_core_obs_t core_obs,
    input wire logic          trace_port_clock,
    input wire logic [2:0]    pipeline_status_lines,
    input wire logic [15:0]   trace_packet_lines,
    input wire logic          branch_sync_flag
);
    wire rd_take = hsel & htrans[1] & hready & ~hwrite;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // ************************************************
    // Port checks
    // ************************************************
    // Falling trace clock edge followed by a rising one: trace was on at the fall
    sequence s_fall_rise;
        $fell(trace_port_clock) ##1 trace_port_clock;
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_hrdata_stands: assert property (!$past(rd_take) |-> $stable(hrdata))
        else $error("read data moved without a read");
    a_trace_port_clock_half: assert property (trace_port_clock |=> !trace_port_clock)
        else $error("trace clock high two cycles");
    a_rise_status: assert property (
        $rose(trace_port_clock) |-> pipeline_status_lines == $past(core_obs.pstat))
        else $error("status wrong at rising trace edge");
    a_fall_status: assert property (
        s_fall_rise |-> $past(pipeline_status_lines) == $past(core_obs.pstat, 2))
        else $error("status wrong at falling trace edge");
    a_idle_quiet: assert property (
        !trace_port_clock && !$past(trace_port_clock) |->
        pipeline_status_lines == 3'h0 && trace_packet_lines == 16'h0 && !branch_sync_flag)
        else $error("trace outputs active while off");
    a_sync_enabled: assert property (branch_sync_flag |-> $changed(trace_port_clock))
        else $error("sync flag without trace edge");
    a_reset_quiet: assert property ($fell(srst) |-> !trace_port_clock &&
        pipeline_status_lines == 3'h0 && trace_packet_lines == 16'h0 && hrdata == 32'h0)
        else $error("outputs not cleared by reset");
endmodule // ttr_trace_unit_chk

bind ttr_trace_unit ttr_trace_unit_chk #(.DEPTH(DEPTH)) u_chk (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .core_obs(core_obs), .trace_port_clock(trace_port_clock),
    .pipeline_status_lines(pipeline_status_lines),
    .trace_packet_lines(trace_packet_lines), .branch_sync_flag(branch_sync_flag)
);

// [ttr_capture_model.sv]
// Trace port analyzer model capturing packet bytes on both trace clock edges
`timescale 1ns/100ps
module ttr_capture_model (
    input wire logic        trace_port_clock,
    input wire logic [15:0] trace_packet_lines,
    input wire logic        branch_sync_flag
);
    // ************************************************
    // Capture store
    // ************************************************
    logic [7:0] got [16];
    logic       syn [16];
    int         n = 0;

    // Both edges carry data; the delay lets the same-edge register updates land
    always @(trace_port_clock) begin
        #1;
        if (trace_packet_lines[7:0] != 8'h00 && n < 16) begin
            got[n] = trace_packet_lines[7:0];
            syn[n] = branch_sync_flag;
            n++;
        end
        if (trace_packet_lines[15:8] != 8'h00 && n < 16) begin
            got[n] = trace_packet_lines[15:8];
            syn[n] = 1'b0;
            n++;
        end
    end
endmodule // ttr_capture_model

// [tb_top.sv]
// Self-checking bench for the trace trigger resources block
`timescale 1ns/100ps
module tb_top;
    import ttr_pkg::*;
    logic          clk_sys, srst, hsel, hwrite, hreadyout, hresp;
    logic [31:0]   haddr, hwdata, hrdata;
    logic [1:0]    htrans;
    logic [2:0]    hsize, pipeline_status_lines;
    logic [15:0]   trace_packet_lines;
    logic          trace_port_clock, branch_sync_flag, trigger_out;
    ttr_core_obs_t core_obs;
    ttr_pkt_t      pkt_in;
    int            error_cnt = 0;
    int            comparisons = 0;

    ttr_trace_unit uut (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .core_obs(core_obs), .pkt_in(pkt_in), .trace_port_clock(trace_port_clock),
        .pipeline_status_lines(pipeline_status_lines),
        .trace_packet_lines(trace_packet_lines), .branch_sync_flag(branch_sync_flag),
        .trigger_out(trigger_out));
    ttr_capture_model cap (.trace_port_clock(trace_port_clock),
        .trace_packet_lines(trace_packet_lines), .branch_sync_flag(branch_sync_flag));

    // ************************************************
    // Shared tasks
    // ************************************************
    task stop_test;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Address phase held until hready, then data phase until hready again
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge clk_sys);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    // One core access; trigger_out reflects it once this returns
    task hit(input logic f, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        core_obs.fetch_vld  <= f;
        core_obs.data_vld   <= !f;
        core_obs.data_ldst  <= !f;
        core_obs.fetch_addr <= a;
        core_obs.data_addr  <= a;
        core_obs.data_val   <= d;
        @(posedge clk_sys);
        core_obs.fetch_vld <= 1'b0;
        core_obs.data_vld  <= 1'b0;
        #1;
    endtask
    task rt(input logic [3:0] r, input logic f, input logic [31:0] a, input logic [31:0] d,
            input logic e);
        wr(A_TRIG, {25'h0, 3'h7, r});
        hit(f, a, d);
        chk({31'h0, trigger_out}, {31'h0, e});
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task s_regs;
        logic [7:0]  a [6];
        logic [31:0] e [6];
        a = '{A_CTRL, A_SEQ, A_TRIG, A_FTHR, A_STAT, 8'h3c};
        e = '{32'h0, 32'hffffff, 32'h0f, 32'h0, 32'h0, 32'h0};
        wr(8'h3c, 32'hffffffff);
        // A narrow write must be dropped, so the threshold reads back as reset
        hsize <= 3'h0;
        wr(A_FTHR, 32'h3f);
        hsize <= 3'h2;
        for (int i = 0; i < 6; i++) rdc(a[i], 32'hffffffff, e[i]);
    endtask
    task s_port;
        logic p;
        wr(A_CTRL, 32'h1);
        #1;
        p = trace_port_clock;
        for (int i = 1; i < 7; i++) begin
            @(posedge clk_sys);
            core_obs.pstat <= 3'(i);
            #1;
            chk({31'h0, trace_port_clock}, {31'h0, !p});
            if (i > 1) chk({29'h0, pipeline_status_lines}, 32'(i - 1));
            p = trace_port_clock;
        end
    endtask
    task s_packets;
        int b;
        b = cap.n;
        @(posedge clk_sys);
        pkt_in <= '{vld: 1'b1, sync: 1'b1, data: 8'h11};
        @(posedge clk_sys);
        pkt_in <= '{vld: 1'b1, sync: 1'b0, data: 8'h22};
        @(posedge clk_sys);
        pkt_in <= '{vld: 1'b1, sync: 1'b0, data: 8'h33};
        @(posedge clk_sys);
        pkt_in.vld <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(32'(cap.n - b), 32'h3);
        for (int i = 0; i < 3; i++) chk({24'h0, cap.got[b + i]}, 32'h11 * (i + 1));
        chk({31'h0, cap.syn[b]}, 32'h1);
        chk({31'h0, cap.syn[b + 1]}, 32'h0);
    endtask
    task s_overflow;
        wr(A_FTHR, 32'd45);
        rdc(A_STAT, 32'h4, 32'h0);
        @(posedge clk_sys);
        pkt_in <= '{vld: 1'b1, sync: 1'b0, data: 8'h44};
        @(posedge clk_sys);
        pkt_in.vld <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdc(A_STAT, 32'h4, 32'h4);
        wr(A_FTHR, 32'h0);
        wr(A_STAT, 32'h4);
        rdc(A_STAT, 32'h4, 32'h0);
    endtask
    task s_sequencer;
        wr(A_TRIG, 32'h4e);
        wr(A_SEQ, 32'hfff8f6);
        hit(1'b0, 32'h00300000, 32'h0);
        rdc(A_STAT, 32'h3, 32'h0);
        hit(1'b0, 32'h002fffff, 32'h0);
        rdc(A_STAT, 32'h3, 32'h1);
        chk({31'h0, trigger_out}, 32'h0);
        hit(1'b0, 32'h00400000, 32'h0);
        rdc(A_STAT, 32'h3, 32'h2);
        chk({31'h0, trigger_out}, 32'h1);
        wr(A_CTRL, 32'h0);
        rdc(A_STAT, 32'h3, 32'h0);
        wr(A_SEQ, 32'hffffff);
    endtask
    task s_compare;
        wr(A_CTRL, 32'h1);
        wr(8'h40, 32'h12345678);
        wr(8'h44, 32'h3);
        wr(8'h48, 32'ha5);
        wr(8'h4c, 32'hffffff00);
        wr(8'h50, 32'h8000);
        wr(8'h54, 32'h0);
        rt(4'd0, 1'b0, 32'h12345678, 32'hdeadbea5, 1'b1);
        rt(4'd0, 1'b0, 32'h12345678, 32'hdeadbe5a, 1'b0);
        rt(4'd0, 1'b1, 32'h12345678, 32'hdeadbea5, 1'b0);
        rt(4'd1, 1'b1, 32'h00008000, 32'h0, 1'b1);
        rt(4'd1, 1'b0, 32'h00008000, 32'h0, 1'b0);
        rt(4'd12, 1'b0, 32'hf0000000, 32'h0, 1'b1);
        rt(4'd12, 1'b0, 32'hffffc000, 32'h0, 1'b0);
        rt(4'd13, 1'b0, 32'hffffc000, 32'h0, 1'b1);
        rt(4'd11, 1'b1, 32'h9fffffff, 32'h0, 1'b1);
        rt(4'd11, 1'b1, 32'ha0000000, 32'h0, 1'b0);
        rt(4'd9, 1'b1, 32'h004fffff, 32'h0, 1'b1);
        wr(A_CTRL, 32'h3);
        wr(8'h40, 32'h1000);
        wr(8'h44, 32'h1);
        wr(8'h50, 32'h2000);
        wr(8'h54, 32'h1);
        rt(4'd4, 1'b0, 32'h00001000, 32'h0, 1'b1);
        rt(4'd4, 1'b0, 32'h00001fff, 32'h0, 1'b1);
        rt(4'd4, 1'b0, 32'h00002000, 32'h0, 1'b0);
        rt(4'd4, 1'b0, 32'h00000fff, 32'h0, 1'b0);
    endtask
    // Reset in mid-run must return the sequencer and control to their start values
    task s_reset;
        wr(A_SEQ, 32'hfffffe);
        rdc(A_STAT, 32'h3, 32'h1);
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        rdc(A_STAT, 32'h3, 32'h0);
        rdc(A_CTRL, 32'hffffffff, 32'h0);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Whole run is a few hundred cycles; this limit only cuts a hang short
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
    initial begin
        srst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        core_obs = '0;
        pkt_in = '0;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        s_regs();
        s_port();
        s_packets();
        s_overflow();
        s_sequencer();
        s_compare();
        s_reset();
        stop_test();
    end
endmodule // tb_top
